// ===== common/decm_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants of the dual event counter monitor.
// ----------------------------------------------------------------------------
package decm_pkg;

	// Channel and width figures.
	localparam int CH_NUM     = 2;
	localparam int CNT_W      = 40;
	localparam int CTL_W      = 32;
	localparam int EVT_NUM    = 64;
	localparam int IDX_W      = 8;
	localparam int CPL_W      = 2;

	// Control word layout; counter 1 fields sit one stride above counter 0.
	localparam int CH_STRIDE  = 16;
	localparam int ES_LSB     = 0;
	localparam int ES_W       = 6;
	localparam int CC_LSB     = 6;
	localparam int CC_W       = 3;
	localparam int PC_BIT     = 9;
	localparam int CC_SUP_BIT = 0;
	localparam int CC_USR_BIT = 1;
	localparam int CC_DUR_BIT = 2;

	// Reset values.
	localparam logic [CTL_W-1:0] CTL_RESET = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_RESET = 40'h00_0000_0000;

	// Model register indices seen by the read and write strobes.
	localparam logic [IDX_W-1:0] IDX_CTL  = 8'h00;
	localparam logic [IDX_W-1:0] IDX_CNT0 = 8'h01;
	localparam logic [IDX_W-1:0] IDX_CNT1 = 8'h02;

	// Privilege levels.
	localparam logic [CPL_W-1:0] CPL_KERNEL = 2'h0;
	localparam logic [CPL_W-1:0] CPL_USER   = 2'h3;

	// Pin path: delay stages before the stretcher, plus the output flop.
	localparam int              PIN_DELAY_STAGES = 4;
	localparam int              PIN_HOLD_W       = 2;
	localparam logic [PIN_HOLD_W-1:0] PIN_HOLD_CYC  = 2'h2;
	localparam logic [PIN_HOLD_W-1:0] PIN_HOLD_ZERO = 2'h0;

endpackage

// ===== design/decm_pin_pipe.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Indicator pin latch, buffer and pulse stretcher for one counter.
// ----------------------------------------------------------------------------
module decm_pin_pipe
	import decm_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic hit_in,
	output logic      pin_out
);

	logic [PIN_DELAY_STAGES-1:0] dly_q;
	logic [PIN_HOLD_W-1:0]       hold_q;

	// Latch and buffer stages so the pin trails the counter event.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dly_q <= '0;
		end else begin
			dly_q <= {dly_q[PIN_DELAY_STAGES-2:0], hit_in};
		end
	end

	// Stretch each indication so a slower external clock still samples it.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			hold_q <= PIN_HOLD_ZERO;
		end else if (dly_q[PIN_DELAY_STAGES-1]) begin
			hold_q <= PIN_HOLD_CYC;
		end else if (hold_q != PIN_HOLD_ZERO) begin
			hold_q <= hold_q - 2'h1;
		end
	end

	// Pin is the delayed hit or a stretch still running.
	assign pin_out = dly_q[PIN_DELAY_STAGES-1] | (hold_q != PIN_HOLD_ZERO);

endmodule // decm_pin_pipe

// ===== design/decm_top.sv
`timescale 1ns/10ps
// What this block does
// - Two independent 40-bit counters, each counting events or clock duration.
// - Control word and counters reachable by model register access only at level 0.
// - Six-bit event code per counter at bits 0-5 and 16-21.
// - Three-bit control field at bits 6-8 and 22-24; 000 and 100 disable.
// - Control top bit picks duration, middle enables level 3, low enables 0-2.
// - Pin function flag at bit 9 or 25: 1 signals overflow, 0 increments.
// - Indicator pin is registered and buffered, trailing the event by a few clocks.
// - Reset clears the whole control word, leaving both counters disabled.
// - Increment mode: pin high per occurrence and throughout a duration condition.
// - Overflow mode: pin stays low until the counter overflows.
// - Counter may add one or two per clock; pin only shows that it happened.
// - Overflow is a carry out of bit 39; presetting sets the distance to it.
// - Overflow shows on the pin about five clocks after it happens.
// - Pin logic tolerates several core clocks per external clock period.
// - Pins can show breakpoint matches; counter functions are then unavailable.
// - Pins default to monitoring after reset; a debugger may switch them.
// - Duration mode adds the number of clocks the condition holds.
module decm_top
	import decm_pkg::*;
(
	input  wire logic             SYS_CLK_IN,
	input  wire logic             SYS_RST_IN,
	input  wire logic             MODEL_REG_READ_IN,
	input  wire logic             MODEL_REG_WRITE_IN,
	input  wire logic [IDX_W-1:0] MODEL_REG_INDEX_IN,
	input  wire logic [CNT_W-1:0] MODEL_REG_WDATA_IN,
	input  wire logic [CPL_W-1:0] CURRENT_PRIVILEGE_LEVEL_IN,
	input  wire logic [EVT_NUM-1:0] EVENT_ACTIVE_IN,
	input  wire logic [EVT_NUM-1:0] EVENT_TWICE_IN,
	input  wire logic             DEBUG_PIN_SEL_WR_IN,
	input  wire logic             DEBUG_PIN_SEL_IN,
	input  wire logic [CH_NUM-1:0] BREAKPOINT_MATCH_IN,
	output logic      [CNT_W-1:0] MODEL_REG_RDATA_OUT,
	output logic                  MODEL_REG_DONE_OUT,
	output logic                  MODEL_REG_FAULT_OUT,
	output logic                  MONITOR_PIN_A_OUT,
	output logic                  MONITOR_PIN_B_OUT,
	output logic                  BREAKPOINT_MODE_OUT
);

	// ------------------------------------------------------------------------
	// Register access decode
	// ------------------------------------------------------------------------

	logic                  access_req;
	logic                  priv_ok;
	logic                  idx_ctl;
	logic                  idx_cnt0;
	logic                  idx_cnt1;
	logic                  idx_hit;
	logic                  access_ok;
	logic                  wr_ctl;
	logic [CH_NUM-1:0]     wr_cnt;

	// A strobe is honoured only at the most privileged level and a mapped index.
	assign access_req = MODEL_REG_READ_IN | MODEL_REG_WRITE_IN;
	assign priv_ok    = (CURRENT_PRIVILEGE_LEVEL_IN == CPL_KERNEL);
	assign idx_ctl    = (MODEL_REG_INDEX_IN == IDX_CTL);
	assign idx_cnt0   = (MODEL_REG_INDEX_IN == IDX_CNT0);
	assign idx_cnt1   = (MODEL_REG_INDEX_IN == IDX_CNT1);
	assign idx_hit    = idx_ctl | idx_cnt0 | idx_cnt1;
	assign access_ok  = access_req & priv_ok & idx_hit;

	// Write strobes per register; a write never touches the other counter.
	assign wr_ctl     = MODEL_REG_WRITE_IN & priv_ok & idx_ctl;
	assign wr_cnt[0]  = MODEL_REG_WRITE_IN & priv_ok & idx_cnt0;
	assign wr_cnt[1]  = MODEL_REG_WRITE_IN & priv_ok & idx_cnt1;

	// ------------------------------------------------------------------------
	// Control word
	// ------------------------------------------------------------------------

	logic [CTL_W-1:0] ctl_q;

	// The whole word is written at once; there is no per-counter write path.
	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			ctl_q <= CTL_RESET;
		end else if (wr_ctl) begin
			ctl_q <= MODEL_REG_WDATA_IN[CTL_W-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// Pin use: monitoring or breakpoint indication
	// ------------------------------------------------------------------------

	logic bkpt_mode_q;

	// Monitoring after reset; only the debugger strobe moves the pins away.
	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			bkpt_mode_q <= 1'b0;
		end else if (DEBUG_PIN_SEL_WR_IN) begin
			bkpt_mode_q <= DEBUG_PIN_SEL_IN;
		end
	end

	assign BREAKPOINT_MODE_OUT = bkpt_mode_q;

	// ------------------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------------------

	logic [CH_NUM*CNT_W-1:0] cnt_flat;
	logic [CH_NUM-1:0]       pin_hit;
	logic [CH_NUM-1:0]       pin_buf;
	logic [CH_NUM-1:0]       ovf_flag;

	genvar ch;
	generate
		for (ch = 0; ch < CH_NUM; ch++) begin : g_ch
			logic [ES_W-1:0]  evt_code;
			logic [CC_W-1:0]  cc;
			logic             pin_ovf_mode;
			logic             cpl_user;
			logic             priv_match;
			logic             duration;
			logic             cond;
			logic             twice;
			logic             inc_en;
			logic [1:0]       inc_amt;
			logic [CNT_W:0]   sum;
			logic [CNT_W-1:0] cnt_q;
			logic             ovf;

			// Field extraction; counter 1 fields sit one stride above.
			assign evt_code     = ctl_q[ch*CH_STRIDE+ES_LSB +: ES_W];
			assign cc           = ctl_q[ch*CH_STRIDE+CC_LSB +: CC_W];
			assign pin_ovf_mode = ctl_q[ch*CH_STRIDE+PC_BIT];

			// Privilege filter: low bit for levels 0 to 2, middle bit for level 3.
			assign cpl_user   = (CURRENT_PRIVILEGE_LEVEL_IN == CPL_USER);
			assign priv_match = (cc[CC_SUP_BIT] & ~cpl_user) |
			                    (cc[CC_USR_BIT] &  cpl_user);
			// Codes 000 and 100 have both privilege bits clear and count nothing.
			assign duration   = cc[CC_DUR_BIT];

			// Selected event condition and its double occurrence.
			assign cond  = EVENT_ACTIVE_IN[evt_code];
			assign twice = EVENT_TWICE_IN[evt_code];

			// Advance only while enabled for this level and the event is present.
			assign inc_en = priv_match & cond;

			// Duration adds one per clock; occurrences may add one or two.
			always_comb begin
				if (!inc_en) begin
					inc_amt = 2'h0;
				end else if (duration) begin
					inc_amt = 2'h1;
				end else if (twice) begin
					inc_amt = 2'h2;
				end else begin
					inc_amt = 2'h1;
				end
			end

			// One bit wider so the carry out of the top bit is overflow.
			assign sum = {1'b0, cnt_q} + {{(CNT_W-1){1'b0}}, inc_amt};
			assign ovf = sum[CNT_W];

			// A privileged write loads every bit and wins over counting.
			always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
				if (SYS_RST_IN) begin
					cnt_q <= CNT_RESET;
				end else if (wr_cnt[ch]) begin
					cnt_q <= MODEL_REG_WDATA_IN;
				end else begin
					cnt_q <= sum[CNT_W-1:0];
				end
			end

			// Pin source: overflow pulse or any increment in this clock.
			assign pin_hit[ch]  = pin_ovf_mode ? ovf : inc_en;
			assign ovf_flag[ch] = ovf;

			assign cnt_flat[ch*CNT_W +: CNT_W] = cnt_q;

			// Latch, buffer and stretch the indication.
			decm_pin_pipe u_pin (
				.clk_in  (SYS_CLK_IN),
				.rst_in  (SYS_RST_IN),
				.hit_in  (pin_hit[ch]),
				.pin_out (pin_buf[ch])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Indicator pin outputs
	// ------------------------------------------------------------------------

	logic [CH_NUM-1:0] pin_q;

	// Final output flop; breakpoint use masks the counter functions.
	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			pin_q <= '0;
		end else if (bkpt_mode_q) begin
			pin_q <= BREAKPOINT_MATCH_IN;
		end else begin
			pin_q <= pin_buf;
		end
	end

	assign MONITOR_PIN_A_OUT = pin_q[0];
	assign MONITOR_PIN_B_OUT = pin_q[1];

	// ------------------------------------------------------------------------
	// Read data and access answer
	// ------------------------------------------------------------------------

	logic [CNT_W-1:0] rd_mux;
	logic [CNT_W-1:0] rdata_q;
	logic             done_q;
	logic             fault_q;

	// Counters may be read while running; the control word reads zero-extended.
	always_comb begin
		rd_mux = CNT_RESET;
		if (idx_ctl) begin
			rd_mux = {{(CNT_W-CTL_W){1'b0}}, ctl_q};
		end else if (idx_cnt0) begin
			rd_mux = cnt_flat[0 +: CNT_W];
		end else if (idx_cnt1) begin
			rd_mux = cnt_flat[CNT_W +: CNT_W];
		end
	end

	// Read data is captured only for an honoured read and otherwise held.
	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			rdata_q <= CNT_RESET;
		end else if (MODEL_REG_READ_IN & access_ok) begin
			rdata_q <= rd_mux;
		end
	end

	// One-cycle answer: done for an honoured access, fault for a refused one.
	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			done_q  <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			done_q  <= access_ok;
			fault_q <= access_req & ~access_ok;
		end
	end

	assign MODEL_REG_RDATA_OUT = rdata_q;
	assign MODEL_REG_DONE_OUT  = done_q;
	assign MODEL_REG_FAULT_OUT = fault_q;

endmodule // decm_top

// ===== testbench/decm_top_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Port checker for the dual event counter monitor.
// ----------------------------------------------------------------------------
module decm_top_assertions
	import decm_pkg::*;
(
	input  wire logic               SYS_CLK_IN,
	input  wire logic               SYS_RST_IN,
	input  wire logic               MODEL_REG_READ_IN,
	input  wire logic               MODEL_REG_WRITE_IN,
	input  wire logic [IDX_W-1:0]   MODEL_REG_INDEX_IN,
	input  wire logic [CPL_W-1:0]   CURRENT_PRIVILEGE_LEVEL_IN,
	input  wire logic [EVT_NUM-1:0] EVENT_ACTIVE_IN,
	input  wire logic               DEBUG_PIN_SEL_WR_IN,
	input  wire logic               DEBUG_PIN_SEL_IN,
	input  wire logic [CH_NUM-1:0]  BREAKPOINT_MATCH_IN,
	input  wire logic [CNT_W-1:0]   MODEL_REG_RDATA_OUT,
	input  wire logic               MODEL_REG_DONE_OUT,
	input  wire logic               MODEL_REG_FAULT_OUT,
	input  wire logic               MONITOR_PIN_A_OUT,
	input  wire logic               MONITOR_PIN_B_OUT,
	input  wire logic               BREAKPOINT_MODE_OUT
);
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	logic acc, good;
	// An access is honoured only at the kernel level on a mapped index.
	assign acc  = MODEL_REG_READ_IN | MODEL_REG_WRITE_IN;
	assign good = (CURRENT_PRIVILEGE_LEVEL_IN == CPL_KERNEL) && (MODEL_REG_INDEX_IN <= IDX_CNT1);
	a_access_done: assert property (acc && good |=> MODEL_REG_DONE_OUT && !MODEL_REG_FAULT_OUT)
		else $error("honoured access gave no done pulse");
	a_access_fault: assert property (acc && !good |=> MODEL_REG_FAULT_OUT && !MODEL_REG_DONE_OUT)
		else $error("refused access gave no fault pulse");
	a_answer_quiet: assert property (!acc |=> !MODEL_REG_DONE_OUT && !MODEL_REG_FAULT_OUT)
		else $error("answer without a request");
	a_rdata_hold: assert property (!(MODEL_REG_READ_IN && good) |=> $stable(MODEL_REG_RDATA_OUT))
		else $error("read data moved without an honoured read");
	a_mode_load: assert property (DEBUG_PIN_SEL_WR_IN |=> BREAKPOINT_MODE_OUT == $past(DEBUG_PIN_SEL_IN))
		else $error("pin use not loaded from debugger strobe");
	a_mode_hold: assert property (!DEBUG_PIN_SEL_WR_IN |=> $stable(BREAKPOINT_MODE_OUT))
		else $error("pin use changed without strobe");
	a_bp_follow: assert property (BREAKPOINT_MODE_OUT ##1 BREAKPOINT_MODE_OUT |->
		{MONITOR_PIN_B_OUT, MONITOR_PIN_A_OUT} == $past(BREAKPOINT_MATCH_IN))
		else $error("pins do not follow breakpoint matches");
	a_pin_stretch: assert property ($rose(MONITOR_PIN_B_OUT) && !BREAKPOINT_MODE_OUT
		&& !$past(BREAKPOINT_MODE_OUT) |=> MONITOR_PIN_B_OUT [*2])
		else $error("indicator pulse shorter than three cycles");
	a_pins_quiet: assert property ((EVENT_ACTIVE_IN == '0 && !BREAKPOINT_MODE_OUT) [*8]
		|-> !MONITOR_PIN_A_OUT && !MONITOR_PIN_B_OUT)
		else $error("indicator high without any cause");
endmodule // decm_top_assertions

bind decm_top decm_top_assertions u_chk (.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
	.MODEL_REG_READ_IN(MODEL_REG_READ_IN), .MODEL_REG_WRITE_IN(MODEL_REG_WRITE_IN),
	.MODEL_REG_INDEX_IN(MODEL_REG_INDEX_IN), .CURRENT_PRIVILEGE_LEVEL_IN(CURRENT_PRIVILEGE_LEVEL_IN),
	.EVENT_ACTIVE_IN(EVENT_ACTIVE_IN), .DEBUG_PIN_SEL_WR_IN(DEBUG_PIN_SEL_WR_IN),
	.DEBUG_PIN_SEL_IN(DEBUG_PIN_SEL_IN), .BREAKPOINT_MATCH_IN(BREAKPOINT_MATCH_IN),
	.MODEL_REG_RDATA_OUT(MODEL_REG_RDATA_OUT), .MODEL_REG_DONE_OUT(MODEL_REG_DONE_OUT),
	.MODEL_REG_FAULT_OUT(MODEL_REG_FAULT_OUT), .MONITOR_PIN_A_OUT(MONITOR_PIN_A_OUT),
	.MONITOR_PIN_B_OUT(MONITOR_PIN_B_OUT), .BREAKPOINT_MODE_OUT(BREAKPOINT_MODE_OUT));

// ===== testbench/decm_sw_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Privileged software issuing model register reads and writes.
// ----------------------------------------------------------------------------
module decm_sw_model
	import decm_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic [CNT_W-1:0] rdata_in,
	input  wire logic             done_in,
	input  wire logic             fault_in,
	output logic                  rd_out,
	output logic                  wr_out,
	output logic      [IDX_W-1:0] idx_out,
	output logic      [CNT_W-1:0] wdata_out,
	output logic      [CPL_W-1:0] cpl_out
);
	logic [CNT_W-1:0] rd_q;
	logic             ok_q;
	// Idle bus at time zero, running at the kernel level.
	initial begin
		{rd_out, wr_out, idx_out, wdata_out} = '0;
		cpl_out = CPL_KERNEL;
	end
	// One access: strobe for one edge, then take the answer it produced.
	task automatic acc(input logic w, input logic [IDX_W-1:0] i, input logic [CNT_W-1:0] d);
		@(posedge clk_in);
		rd_out    <= ~w;
		wr_out    <= w;
		idx_out   <= i;
		wdata_out <= d;
		@(posedge clk_in);
		{rd_out, wr_out} <= 2'h0;
		wdata_out <= ~d;
		#1;
		ok_q = done_in & ~fault_in;
		rd_q = rdata_in;
	endtask
	// Stops a channel, presets it, then writes back the whole control word.
	task automatic prog(input int ch, input logic [15:0] f, input logic [CNT_W-1:0] pre);
		logic [CTL_W-1:0] w;
		acc(1'b0, IDX_CTL, '0);
		w = rd_q[CTL_W-1:0];
		w[ch*CH_STRIDE+CC_LSB +: CC_W] = 3'h0;
		acc(1'b1, IDX_CTL, {8'h00, w});
		acc(1'b1, (ch == 0) ? IDX_CNT0 : IDX_CNT1, pre);
		w[ch*CH_STRIDE +: 16] = f;
		acc(1'b1, IDX_CTL, {8'h00, w});
	endtask
endmodule // decm_sw_model

// ===== testbench/dual_event_counter_monitor_test.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Self-checking bench of the dual event counter monitor.
// ----------------------------------------------------------------------------
module dual_event_counter_monitor_test
	import decm_pkg::*;
;
	logic               clk, rst, rd, wr, done, fault, pa, pb, bmode, dsw, dsel;
	logic [IDX_W-1:0]   idx;
	logic [CNT_W-1:0]   wd, rdata;
	logic [CPL_W-1:0]   current_privilege_level;
	logic [EVT_NUM-1:0] ev, tw;
	logic [CH_NUM-1:0]  bpm;
	int                 err_total, n_compared, wid;
	decm_top dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .MODEL_REG_READ_IN(rd),
		.MODEL_REG_WRITE_IN(wr), .MODEL_REG_INDEX_IN(idx), .MODEL_REG_WDATA_IN(wd),
		.CURRENT_PRIVILEGE_LEVEL_IN(current_privilege_level), .EVENT_ACTIVE_IN(ev), .EVENT_TWICE_IN(tw),
		.DEBUG_PIN_SEL_WR_IN(dsw), .DEBUG_PIN_SEL_IN(dsel), .BREAKPOINT_MATCH_IN(bpm),
		.MODEL_REG_RDATA_OUT(rdata), .MODEL_REG_DONE_OUT(done), .MODEL_REG_FAULT_OUT(fault),
		.MONITOR_PIN_A_OUT(pa), .MONITOR_PIN_B_OUT(pb), .BREAKPOINT_MODE_OUT(bmode));
	decm_sw_model sw (.clk_in(clk), .rdata_in(rdata), .done_in(done), .fault_in(fault),
		.rd_out(rd), .wr_out(wr), .idx_out(idx), .wdata_out(wd), .cpl_out(current_privilege_level));
	// Free running core clock at 50 MHz.
	always #10 clk = ~clk;
	// Compares one value and counts the outcome.
	task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	// Reads one register and compares it.
	task automatic rdv(input logic [IDX_W-1:0] i, input logic [CNT_W-1:0] e, input string m);
		sw.acc(1'b0, i, '0);
		chk(sw.rd_q, e, m);
	endtask
	// Holds event 5 at a privilege level for n clocks.
	task automatic run(input logic [CPL_W-1:0] l, input int n);
		@(posedge clk);
		{ev[5], tw[5]} <= 2'h3;
		sw.cpl_out <= l;
		repeat (n) @(posedge clk);
		{ev[5], tw[5]} <= 2'h0;
		sw.cpl_out <= CPL_KERNEL;
	endtask
	// Event 9 for n clocks; counts pin B high cycles from the first hit on.
	task automatic pulse(input int n, input logic t);
		@(posedge clk);
		{ev[9], tw[9]} <= {1'b1, t};
		wid = 0;
		for (int k = 1; k <= n + 20; k++) begin
			@(posedge clk);
			if (k == n) begin
				{ev[9], tw[9]} <= 2'h0;
			end
			#1 wid += pb;
		end
	endtask
	// Reset values and refused accesses.
	task automatic t_access();
		rdv(IDX_CTL, '0, "control after reset");
		sw.acc(1'b1, IDX_CNT1, 40'h92_3456_789A);
		rdv(IDX_CNT1, 40'h92_3456_789A, "full load");
		@(posedge clk);
		sw.cpl_out <= CPL_USER;
		sw.acc(1'b1, IDX_CNT1, '0);
		chk(sw.ok_q, 1'h0, "user write");
		sw.cpl_out <= CPL_KERNEL;
		sw.acc(1'b0, 8'h03, '0);
		chk(sw.ok_q, 1'h0, "unmapped read");
		rdv(IDX_CNT1, 40'h92_3456_789A, "refused write");
		$display("test access done");
	endtask
	// Every control code, at kernel and user level, twice per clock.
	task automatic t_modes();
		logic [CNT_W-1:0] e;
		for (int c = 0; c < 8; c++) begin
			sw.prog(0, {7'h00, c[2:0], 6'h05}, '0);
			run(CPL_KERNEL, 4);
			run(CPL_USER, 4);
			e = (c[0] ? 40'h4 : 40'h0) + (c[1] ? 40'h4 : 40'h0);
			e = c[2] ? e : e * 2;
			rdv(IDX_CNT0, e, "count per code");
		end
		$display("test modes done");
	endtask
	// Increment and overflow signalling on pin B.
	task automatic t_pins();
		sw.prog(1, 16'h00C9, '0);
		pulse(1, 1'b1);
		chk(wid, 3, "single hit width");
		sw.prog(1, 16'h01C9, '0);
		pulse(10, 1'b0);
		chk(wid, 12, "duration width");
		sw.prog(1, 16'h02C9, 40'hFF_FFFF_FFFE);
		pulse(1, 1'b0);
		chk(wid, 0, "no overflow yet");
		pulse(1, 1'b1);
		chk(wid, 3, "overflow pulse");
		rdv(IDX_CNT1, 40'h1, "wrapped count");
		$display("test pins done");
	endtask
	// Breakpoint use of the pins and return to monitoring.
	task automatic t_bp();
		@(posedge clk);
		{dsw, dsel} <= 2'h3;
		@(posedge clk);
		dsw <= 1'b0;
		bpm <= 2'h2;
		repeat (2) @(posedge clk);
		#1 chk({bmode, pb, pa}, 3'h6, "breakpoint match");
		@(posedge clk);
		{dsw, dsel, bpm} <= 4'h8;
		pulse(1, 1'b0);
		chk({bmode, wid[4:0]}, 6'h0, "back to monitoring");
		$display("test breakpoint done");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Main sequence after a ten clock reset.
	initial begin
		{clk, rst, ev, tw, dsw, dsel, bpm} = 1'b1 << (2 * EVT_NUM + 4);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_access();
		t_modes();
		t_pins();
		t_bp();
		results();
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		#400000;
		err_total++;
		$display("mismatch at %0t: watchdog expired", $time);
		results();
	end
endmodule // dual_event_counter_monitor_test
